// *** logic/qpsc_pkg.sv ***
// Package for the four-channel pot serial control block.
// Shared by the control top and the nonvolatile store module.
package qpsc_pkg;
    // ==========================================
    // Framing and register map
    localparam logic [7:0] ID_BYTE = 8'h50;
    localparam logic [3:0] OP_READ = 4'hb;
    localparam logic [3:0] OP_WRITE = 4'hc;
    localparam logic [3:0] ADDR_ACR = 4'h8;
    localparam logic [3:0] ADDR_LAST_NV = 4'h6;
    localparam int NUM_CH = 4;
    localparam int NV_WORDS = 7;
    // ==========================================
    // Access control bits, reset values and wiper end codes
    localparam int ACR_VOL_BIT = 7;
    localparam int ACR_PD_BIT = 6;
    localparam int ACR_BUSY_BIT = 5;
    localparam logic ACR_VOL_RST = 1'b0;
    localparam logic ACR_PD_RST = 1'b1;
    localparam logic [6:0] WIPER_MID = 7'h40;
    localparam logic [6:0] WIPER_TOP = 7'h7f;
    localparam logic [6:0] WIPER_BOTTOM = 7'h00;
    localparam logic [7:0] NV_ERASED = 8'h40;
    // ==========================================
    // Timing
    localparam int CLK_MHZ = 25;
    localparam int NV_WRITE_MS = 20;
    localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000 * CLK_MHZ;
    // ==========================================
    // Types
    typedef enum logic [1:0] {
        QPSC_ID = 2'b00,
        QPSC_CMD = 2'b01,
        QPSC_DATA = 2'b10,
        QPSC_IGNORE = 2'b11
    } qpsc_phase_t;
    typedef struct packed {
        logic [6:0] wiper;
        logic high_open;
        logic wiper_to_low;
    } qpsc_chan_t;
endpackage

// *** logic/qpsc_nvmem.sv ***
// Nonvolatile word store for initial wiper values and spare words.
// Assumes contents persist across power loss in the real array.
`timescale 1ns/1ps
module qpsc_nvmem (
    // Clock
    input wire logic i_mclk,
    // Write port
    input wire logic i_we,
    input wire logic [2:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // Read port
    input wire logic [2:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:qpsc_pkg::NV_WORDS-1];

    initial begin
        for (int k = 0; k < qpsc_pkg::NV_WORDS; k++) begin
            mem[k] = qpsc_pkg::NV_ERASED;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// *** logic/qpsc_ctrl.sv ***
// Serial control top of the four-channel digital pot.
// Assumes i_sck, i_cs_n, i_sdi, i_pd_pin_n arrive asynchronous to i_mclk;
// i_rst_n models power-up.
`timescale 1ns/1ps
module qpsc_ctrl #(
    parameter int NV_CYC = qpsc_pkg::NV_WRITE_CYC
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Serial pins
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    output logic o_sdo_out,
    output logic o_sdo_oe_n,
    // Shutdown pin
    input wire logic i_pd_pin_n,
    // Pot channels
    output qpsc_pkg::qpsc_chan_t [3:0] o_chan,
    // Status
    output logic o_active,
    output logic o_nv_write_busy,
    output logic o_recall_done
);
    // ==========================================
    // Input synchronisers
    logic [3:0] sync1, sync2, sync3;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Idle levels: clock low, others high
            sync1 <= 4'h7;
            sync2 <= 4'h7;
            sync3 <= 4'h7;
        end else begin
            sync1 <= {i_sck, i_cs_n, i_sdi, i_pd_pin_n};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    logic sck, sck_d, cs_n, cs_d, sdi, pd_pin;
    assign sck = sync2[3];
    assign sck_d = sync3[3];
    assign cs_n = sync2[2];
    assign cs_d = sync3[2];
    assign sdi = sync2[1];
    assign pd_pin = sync2[0];
    logic sck_rise, sck_fall, cs_rise, sel;
    assign sel = !cs_n;
    assign sck_rise = sel && sck && !sck_d;
    assign sck_fall = sel && !sck && sck_d;
    assign cs_rise = cs_n && !cs_d;

    // ==========================================
    // State
    qpsc_pkg::qpsc_phase_t phase, next_phase;
    logic [2:0] bitcnt, next_bitcnt;
    logic [7:0] shin, next_shin;
    logic [7:0] shout, next_shout;
    logic [3:0] ptr, next_ptr;
    logic rd_mode, next_rd_mode;
    logic [6:0] wiper [0:3];
    logic [6:0] next_wiper [0:3];
    logic acr_vol, next_acr_vol, acr_pd, next_acr_pd;
    logic nv_pend, next_nv_pend;
    logic [2:0] nv_addr, next_nv_addr;
    logic [7:0] nv_data, next_nv_data;
    logic [31:0] busy_cnt, next_busy_cnt;
    logic [2:0] rec, next_rec;
    logic rec_done;
    logic sdo_bit, next_sdo_bit;
    logic nv_we, busy;
    logic [7:0] nv_rdata;
    logic [2:0] nv_raddr;

    assign busy = busy_cnt != 32'h0;
    assign rec_done = rec == 3'(qpsc_pkg::NUM_CH + 1);

    qpsc_nvmem u_nv (
        .i_mclk(i_mclk),
        .i_we(nv_we),
        .i_waddr(nv_addr),
        .i_wdata(nv_data),
        .i_raddr(nv_raddr),
        .o_rdata(nv_rdata)
    );

    // Register read mux
    function automatic logic [7:0] rd_val(input logic [3:0] a, input logic [7:0] nvd,
                                           input logic volatile_only_select, input logic pd, input logic b,
                                           input logic [6:0] w);
        if (a == qpsc_pkg::ADDR_ACR) begin
            rd_val = {volatile_only_select, pd, b, 5'h00};
        end else if (a < 4'h4 && volatile_only_select) begin
            rd_val = {1'b0, w};
        end else if (a <= qpsc_pkg::ADDR_LAST_NV) begin
            rd_val = nvd;
        end else begin
            rd_val = 8'h00;
        end
    endfunction

    function automatic logic [3:0] ptr_inc(input logic [3:0] a);
        ptr_inc = (a >= qpsc_pkg::ADDR_LAST_NV) ? 4'h0 : a + 4'h1;
    endfunction

    // Nonvolatile read address: recall walks channels, else follows pointer
    assign nv_raddr = (rec < 3'h4) ? {1'b0, rec[1:0]} : ((ptr <= qpsc_pkg::ADDR_LAST_NV) ?
                      ptr[2:0] : 3'h0);

    // ==========================================
    // Next state
    always_comb begin
        logic [7:0] byte_in;
        logic [7:0] byte_out;
        byte_in = {shin[6:0], sdi};
        byte_out = rd_val(ptr, nv_rdata, acr_vol, acr_pd, busy, wiper[ptr[1:0]]);
        next_phase = phase;
        next_bitcnt = bitcnt;
        next_shin = shin;
        next_shout = shout;
        next_ptr = ptr;
        next_rd_mode = rd_mode;
        next_acr_vol = acr_vol;
        next_acr_pd = acr_pd;
        next_nv_pend = nv_pend;
        next_nv_addr = nv_addr;
        next_nv_data = nv_data;
        next_busy_cnt = busy ? busy_cnt - 32'h1 : busy_cnt;
        next_rec = rec;
        next_sdo_bit = sdo_bit;
        nv_we = 1'b0;
        for (int c = 0; c < 4; c++) begin
            next_wiper[c] = wiper[c];
        end
        if (!rec_done) begin
            next_rec = rec + 3'h1;
            if (rec != 3'h0) begin
                next_wiper[2'(rec - 3'h1)] = nv_rdata[6:0];
            end
        end
        // Abort on deselect; start timed write
        if (cs_rise) begin
            next_phase = qpsc_pkg::QPSC_ID;
            next_bitcnt = 3'h0;
            next_sdo_bit = 1'b1;
            if (nv_pend) begin
                next_nv_pend = 1'b0;
                nv_we = 1'b1;
                next_busy_cnt = 32'(NV_CYC);
            end
        end else if (sck_rise) begin
            next_shin = byte_in;
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == 3'h7) begin
                unique case (phase)
                    qpsc_pkg::QPSC_ID: begin
                        next_phase = (byte_in == qpsc_pkg::ID_BYTE) ? qpsc_pkg::QPSC_CMD :
                                     qpsc_pkg::QPSC_IGNORE;
                    end
                    qpsc_pkg::QPSC_CMD: begin
                        next_ptr = byte_in[3:0];
                        next_rd_mode = byte_in[7:4] == qpsc_pkg::OP_READ;
                        next_phase = (byte_in[7:4] == qpsc_pkg::OP_READ ||
                                      byte_in[7:4] == qpsc_pkg::OP_WRITE) ?
                                     qpsc_pkg::QPSC_DATA : qpsc_pkg::QPSC_IGNORE;
                    end
                    qpsc_pkg::QPSC_DATA: begin
                        if (!rd_mode && !busy) begin
                            if (ptr == qpsc_pkg::ADDR_ACR) begin
                                next_acr_vol = byte_in[qpsc_pkg::ACR_VOL_BIT];
                                next_acr_pd = byte_in[qpsc_pkg::ACR_PD_BIT];
                            end else if (ptr <= qpsc_pkg::ADDR_LAST_NV) begin
                                if (ptr < 4'h4) begin
                                    next_wiper[ptr[1:0]] = byte_in[6:0];
                                end
                                if (!(acr_vol && ptr < 4'h4)) begin
                                    next_nv_pend = 1'b1;
                                    next_nv_addr = ptr[2:0];
                                    next_nv_data = byte_in;
                                end
                            end
                        end
                        if (ptr != qpsc_pkg::ADDR_ACR) begin
                            next_ptr = ptr_inc(ptr);
                        end
                    end
                    qpsc_pkg::QPSC_IGNORE: begin
                        next_phase = qpsc_pkg::QPSC_IGNORE;
                    end
                endcase
            end
        end else if (sck_fall) begin
            if (phase == qpsc_pkg::QPSC_DATA && rd_mode && bitcnt == 3'h0) begin
                // Byte taken once pointer and store output have settled
                next_shout = byte_out;
                next_sdo_bit = byte_out[7];
            end else if (phase == qpsc_pkg::QPSC_DATA && rd_mode) begin
                next_sdo_bit = shout[3'h7 - bitcnt];
            end else begin
                next_sdo_bit = 1'b1;
            end
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase <= qpsc_pkg::QPSC_ID;
            bitcnt <= 3'h0;
            shin <= 8'h00;
            shout <= 8'h00;
            ptr <= 4'h0;
            rd_mode <= 1'b0;
            acr_vol <= qpsc_pkg::ACR_VOL_RST;
            acr_pd <= qpsc_pkg::ACR_PD_RST;
            nv_pend <= 1'b0;
            nv_addr <= 3'h0;
            nv_data <= 8'h00;
            busy_cnt <= 32'h0;
            rec <= 3'h0;
            sdo_bit <= 1'b1;
            for (int c = 0; c < 4; c++) begin
                wiper[c] <= qpsc_pkg::WIPER_MID;
            end
        end else begin
            phase <= next_phase;
            bitcnt <= next_bitcnt;
            shin <= next_shin;
            shout <= next_shout;
            ptr <= next_ptr;
            rd_mode <= next_rd_mode;
            acr_vol <= next_acr_vol;
            acr_pd <= next_acr_pd;
            nv_pend <= next_nv_pend;
            nv_addr <= next_nv_addr;
            nv_data <= next_nv_data;
            busy_cnt <= next_busy_cnt;
            rec <= next_rec;
            sdo_bit <= next_sdo_bit;
            for (int c = 0; c < 4; c++) begin
                wiper[c] <= next_wiper[c];
            end
        end
    end

    // ==========================================
    // Outputs
    logic shut;
    assign shut = !(pd_pin && acr_pd);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sdo_out <= 1'b0;
            o_sdo_oe_n <= 1'b1;
            o_active <= 1'b0;
            o_nv_write_busy <= 1'b0;
            o_recall_done <= 1'b0;
            o_chan <= '0;
        end else begin
            // Released when deselected; open drain drives low only
            o_sdo_out <= 1'b0;
            o_sdo_oe_n <= cs_n || next_sdo_bit;
            o_active <= !cs_n || busy || nv_pend;
            o_nv_write_busy <= busy;
            o_recall_done <= rec_done;
            for (int c = 0; c < 4; c++) begin
                // Wiper code passes straight to tap
                o_chan[c].wiper <= wiper[c];
                o_chan[c].high_open <= shut;
                o_chan[c].wiper_to_low <= shut;
            end
        end
    end

    // ==========================================
    // Assertions
    property p_shut;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!pd_pin || !acr_pd) |=> (o_chan[0].high_open && o_chan[3].wiper_to_low);
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown not applied");

    property p_restore;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (pd_pin && acr_pd) |=> (!o_chan[1].high_open && o_chan[1].wiper == $past(wiper[1]));
    endproperty
    a_restore: assert property (p_restore) else $error("wiper not restored");

    property p_release;
        @(posedge i_mclk) disable iff (!i_rst_n)
        cs_n |=> o_sdo_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("sdo driven while deselected");

    property p_active;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !cs_n |=> o_active;
    endproperty
    a_active: assert property (p_active) else $error("not active when selected");

    property p_standby;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (cs_n && !busy && !nv_pend) |=> !o_active;
    endproperty
    a_standby: assert property (p_standby) else $error("no standby");

    sequence s_nv_run;
        busy ##1 o_nv_write_busy;
    endsequence

    property p_nvstart;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (cs_rise && nv_pend) |=> s_nv_run;
    endproperty
    a_nvstart: assert property (p_nvstart) else $error("nv write not started");

    property p_abort;
        @(posedge i_mclk) disable iff (!i_rst_n)
        cs_rise |=> (bitcnt == 3'h0 && phase == qpsc_pkg::QPSC_ID);
    endproperty
    a_abort: assert property (p_abort) else $error("transfer not aborted");

    property p_busy_lock;
        @(posedge i_mclk) disable iff (!i_rst_n)
        busy |=> $stable(acr_pd) && $stable(acr_vol);
    endproperty
    a_busy_lock: assert property (p_busy_lock) else $error("write while busy");

    property p_recall;
        @(posedge i_mclk) disable iff (!i_rst_n)
        $rose(rec_done) |-> wiper[3] == $past(nv_rdata[6:0]);
    endproperty
    a_recall: assert property (p_recall) else $error("recall mismatch");
endmodule

// *** sim/qpsc_host.sv ***
// Serial host model for the pot control block: mode 0, MSB first.
// Assumes it shares the control block's clock and that SDO has a pull-up.
`timescale 1ns/1ps
module qpsc_host (
    // Clock
    input wire logic i_mclk,
    // Serial pins
    input wire logic i_sdo,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_sdi
);
    // ==========================================
    // Idle levels, link clock parked low
    initial begin
        o_sck = 1'h0;
        o_cs_n = 1'h1;
        o_sdi = 1'h1;
    end

    // Half of a 320 ns link clock period
    task automatic half();
        repeat (4) @(posedge i_mclk);
    endtask

    // ==========================================
    // One framed transfer; the last data byte comes back in rx
    // select falls before any bit
    // bytes sent as composed by the bench
    task automatic frame(input logic [23:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge i_mclk);
        o_cs_n <= 1'h0;
        half();
        for (int i = 0; i < nbits; i++) begin
            o_sdi <= tx[23 - i];
            half();
            o_sck <= 1'h1;
            half();
            // Read bit stands until the next falling edge
            if (i >= 16) begin
                rx = {rx[6:0], i_sdo};
            end
            o_sck <= 1'h0;
        end
        half();
        o_cs_n <= 1'h1;
        // Released data line shows the inverse, not the last bit
        o_sdi <= ~o_sdi;
        // Deselect time before the next frame
        repeat (60) @(posedge i_mclk);
    endtask
endmodule

// *** sim/quad_pot_serial_ctrl_tb.sv ***
// Self-checking bench for the four-channel pot serial control block.
// Assumes the host model in qpsc_host.sv and a short nonvolatile write time.
`timescale 1ns/1ps
module quad_pot_serial_ctrl_tb;
    localparam int NV_CYC = 1000;
    logic i_mclk;
    logic i_rst_n;
    logic i_pd_pin_n;
    logic sck, cs_n, sdi, sdo_out, sdo_oe_n, sdo;
    qpsc_pkg::qpsc_chan_t [3:0] chan;
    logic active, busy, recall_done;
    int mismatches;
    int n_compared;
    int c;
    int n;
    logic [31:0] seed;
    logic [7:0] rd_val;
    logic [6:0] v;

    // ==========================================
    // Design, host and pull-up on the open-drain line
    qpsc_ctrl #(.NV_CYC(NV_CYC)) dut_u (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_sdi(sdi),
        .o_sdo_out(sdo_out), .o_sdo_oe_n(sdo_oe_n), .i_pd_pin_n(i_pd_pin_n),
        .o_chan(chan), .o_active(active), .o_nv_write_busy(busy),
        .o_recall_done(recall_done));
    qpsc_host host_u (.i_mclk(i_mclk), .i_sdo(sdo), .o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi));
    assign sdo = sdo_oe_n ? 1'h1 : sdo_out;

    initial begin
        i_mclk = 1'h0;
        forever #20 i_mclk = ~i_mclk;
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] acr_val(input logic volatile_only_select, input logic pd, input logic b);
        return {volatile_only_select, pd, b, 5'h00};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        host_u.frame({qpsc_pkg::ID_BYTE, qpsc_pkg::OP_WRITE, a, d}, 24, dummy);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        host_u.frame({qpsc_pkg::ID_BYTE, qpsc_pkg::OP_READ, a, 8'hff}, 24, d);
    endtask
    task automatic power_up();
        i_rst_n <= 1'h0;
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'h1;
        for (int k = 0; k < 100 && recall_done !== 1'h1; k++) @(posedge i_mclk);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge i_mclk);
        mismatches++;
        stop_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        i_rst_n = 1'h0;
        i_pd_pin_n = 1'h1;
        mismatches = 0;
        n_compared = 0;
        seed = 32'h380e6314;
        power_up();
        for (c = 0; c < 4; c++) chk("wiper", 8'h40, {1'h0, chan[c].wiper});
        chk("sdo_oe_n", 8'h01, {7'h00, sdo_oe_n});
        chk("active", 8'h00, {7'h00, active});
        fork
            rd(qpsc_pkg::ADDR_ACR, rd_val);
            begin
                repeat (100) @(posedge i_mclk);
                chk("active", 8'h01, {7'h00, active});
            end
        join
        chk("acr", acr_val(1'h0, 1'h1, 1'h0), rd_val);
        wr(qpsc_pkg::ADDR_ACR, acr_val(1'h1, 1'h1, 1'h0));
        // Random wiper traffic with both end codes first
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            c = int'(seed[1:0]);
            v = (k == 0) ? 7'h7f : (k == 1) ? 7'h00 : seed[8:2];
            wr(4'(c), {1'h0, v});
            chk("wiper", {1'h0, v}, {1'h0, chan[c].wiper});
            rd(4'(c), rd_val);
            chk("read", {1'h0, v}, rd_val);
        end
        chk("busy", 8'h00, {7'h00, busy});
        chk("active", 8'h00, {7'h00, active});
        host_u.frame({qpsc_pkg::ID_BYTE, qpsc_pkg::OP_WRITE, 4'h1, 8'h00}, 12, rd_val);
        wr(4'h1, 8'h2a);
        chk("wiper", 8'h2a, {1'h0, chan[1].wiper});
        host_u.frame({8'h51, qpsc_pkg::OP_WRITE, 4'h1, 8'h11}, 24, rd_val);
        chk("wiper", 8'h2a, {1'h0, chan[1].wiper});
        // Shutdown through the pin
        i_pd_pin_n <= 1'h0;
        repeat (8) @(posedge i_mclk);
        for (c = 0; c < 4; c++) chk("sd", 8'h03, {6'h00, chan[c].high_open, chan[c].wiper_to_low});
        wr(4'h1, 8'h15);
        rd(4'h1, rd_val);
        chk("read", 8'h15, rd_val);
        i_pd_pin_n <= 1'h1;
        repeat (8) @(posedge i_mclk);
        chk("wiper", 8'h15, {1'h0, chan[1].wiper});
        chk("sd", 8'h00, {6'h00, chan[1].high_open, chan[1].wiper_to_low});
        // Shutdown through the control bit
        wr(qpsc_pkg::ADDR_ACR, acr_val(1'h1, 1'h0, 1'h0));
        chk("sd", 8'h03, {6'h00, chan[2].high_open, chan[2].wiper_to_low});
        rd(qpsc_pkg::ADDR_ACR, rd_val);
        chk("acr", acr_val(1'h1, 1'h0, 1'h0), rd_val);
        wr(qpsc_pkg::ADDR_ACR, acr_val(1'h1, 1'h1, 1'h0));
        chk("sd", 8'h00, {6'h00, chan[2].high_open, chan[2].wiper_to_low});
        // Nonvolatile write and the busy window
        v = chan[2].wiper;
        wr(qpsc_pkg::ADDR_ACR, acr_val(1'h0, 1'h1, 1'h0));
        wr(4'h1, 8'h33);
        chk("busy", 8'h01, {7'h00, busy});
        chk("active", 8'h01, {7'h00, active});
        rd(qpsc_pkg::ADDR_ACR, rd_val);
        chk("acr", acr_val(1'h0, 1'h1, 1'h1), rd_val);
        wr(4'h2, 8'h55);
        chk("wiper", {1'h0, v}, {1'h0, chan[2].wiper});
        for (n = 0; n < 1000 && busy !== 1'h0; n++) @(posedge i_mclk);
        repeat (8) @(posedge i_mclk);
        chk("busy", 8'h00, {7'h00, busy});
        chk("active", 8'h00, {7'h00, active});
        // Stored word for the last channel
        seed = xs(seed);
        v = seed[6:0];
        wr(4'h3, {1'h0, v});
        for (n = 0; n < 1000 && busy !== 1'h0; n++) @(posedge i_mclk);
        // Power cycle recalls the stored words
        power_up();
        repeat (2) @(posedge i_mclk);
        chk("wiper", 8'h33, {1'h0, chan[1].wiper});
        chk("wiper", 8'h40, {1'h0, chan[0].wiper});
        chk("wiper", {1'h0, v}, {1'h0, chan[3].wiper});
        // Volatile select back at zero reads the stored word
        rd(4'h1, rd_val);
        chk("read", 8'h33, rd_val);
        stop_test();
    end
endmodule
